/* logic/transport_end_dev.sv */
/*
 * device end of the control transport link: opens, carries and closes
 * a connection with one peer, stop and wait with retransmission.
 * assumes a peer that keeps the same protocol, one clock, sync reset.
 */
`timescale 1ns/100ps
`include "transport_defines.svh"

module transport_end_dev (
	input wire logic mclk,
	input wire logic rst,
	transport_link_if.dev_end link,
	input wire logic open_cmd,
	input wire logic close_cmd,
	input wire logic tx_req,
	input wire transport_pkg::data_t tx_data,
	output logic tx_taken,
	output logic rx_valid,
	output transport_pkg::data_t rx_data,
	output logic rx_reject,
	output transport_pkg::conn_state_t conn_state
);

	// ************************************************************
	// constants and state
	// ************************************************************
	localparam transport_pkg::seq_t SEQ_ONE = `TC_SEQ_W'(1);
	localparam logic [`TC_TMR_W-1:0] TMR_LIMIT =
		`TC_TMR_W'(`TC_RETX_CYCLES - 1);
	localparam logic [`TC_TMR_W-1:0] TMR_ONE = `TC_TMR_W'(1);

	transport_pkg::conn_state_t state_reg, state_next;
	transport_pkg::seq_t snd_seq_reg, snd_seq_next;
	transport_pkg::seq_t exp_reg, exp_next;
	transport_pkg::hdr_t una_hdr_reg, una_hdr_next;
	transport_pkg::hdr_t tx_hdr_reg, tx_hdr_next;
	transport_pkg::data_t rx_data_reg, rx_data_next;
	transport_pkg::flag_t pl_flag;
	logic [`TC_TMR_W-1:0] tmr_reg, tmr_next;
	logic una_reg, una_next;
	logic role_reg, role_next;
	logic want_close_reg, want_close_next;
	logic ack_due_reg, ack_due_next;
	logic tx_valid_reg, tx_valid_next;
	logic rx_valid_reg, rx_valid_next;
	logic taken_reg, taken_next;
	logic reject_reg, reject_next;
	logic send_pl, send_ack, pl_ok, pl_has;

	// ************************************************************
	// receive decode
	// ************************************************************
	// incoming header and its classification
	transport_pkg::hdr_t rx_hdr;
	logic rx_got, carries, in_order, ack_hit, timed_out, is_close;
	assign rx_got = link.b2a_valid;
	assign rx_hdr = link.b2a_hdr;
	assign is_close = rx_hdr.flag == transport_pkg::FLAG_CLOSE;
	// a close code counts as payload like a logical packet
	assign carries = rx_hdr.has_data || is_close;
	assign in_order = rx_got && rx_hdr.seq == exp_reg;
	assign ack_hit = rx_got && rx_hdr.ack_ok && una_reg &&
		rx_hdr.ack == snd_seq_reg;
	assign timed_out = una_reg && tmr_reg == TMR_LIMIT;

	// ************************************************************
	// connection sequencing
	// ************************************************************
	// next state, sequence counters and what to send
	always_comb begin
		state_next = state_reg;
		snd_seq_next = snd_seq_reg;
		exp_next = exp_reg;
		una_next = una_reg && !ack_hit;
		una_hdr_next = una_hdr_reg;
		tmr_next = (una_reg && !timed_out) ? tmr_reg + TMR_ONE : '0;
		role_next = role_reg;
		want_close_next = want_close_reg ||
			(close_cmd && state_reg == transport_pkg::ST_OPEN);
		ack_due_next = ack_due_reg;
		tx_valid_next = 1'b0;
		tx_hdr_next = tx_hdr_reg;
		rx_valid_next = 1'b0;
		rx_data_next = rx_data_reg;
		taken_next = 1'b0;
		reject_next = 1'b0;
		send_pl = 1'b0;
		send_ack = 1'b0;
		pl_ok = 1'b1;
		pl_has = 1'b0;
		pl_flag = transport_pkg::FLAG_NONE;
		// acknowledge payload, gaps get a duplicate
		if (state_reg[1] && rx_got && carries) begin
			ack_due_next = 1'b1;
			if (in_order) begin
				exp_next = rx_hdr.seq + SEQ_ONE;
				rx_valid_next = rx_hdr.has_data;
				rx_data_next = rx_hdr.has_data ? rx_hdr.data : rx_data_reg;
			end
		end
		case (state_reg)
			transport_pkg::ST_CLOSED: begin
				una_next = 1'b0;
				ack_due_next = 1'b0;
				want_close_next = 1'b0;
				if (rx_got && rx_hdr.flag == transport_pkg::FLAG_OPEN &&
					!rx_hdr.ack_ok) begin
					exp_next = rx_hdr.seq + SEQ_ONE;
					send_pl = 1'b1;
					pl_flag = transport_pkg::FLAG_OPEN;
					role_next = 1'b0;
					state_next = transport_pkg::ST_OPENING;
				end else if (rx_got) begin
					reject_next = 1'b1;
				end else if (open_cmd) begin
					send_pl = 1'b1;
					pl_ok = 1'b0;
					pl_flag = transport_pkg::FLAG_OPEN;
					role_next = 1'b1;
					state_next = transport_pkg::ST_OPENING;
				end
			end
			transport_pkg::ST_OPENING: begin
				if (ack_hit && role_reg &&
					rx_hdr.flag == transport_pkg::FLAG_OPEN) begin
					exp_next = rx_hdr.seq + SEQ_ONE;
					send_ack = 1'b1;
					state_next = transport_pkg::ST_OPEN;
				end else if (ack_hit && !role_reg) begin
					state_next = transport_pkg::ST_OPEN;
				end
			end
			transport_pkg::ST_OPEN: begin
				if (in_order && is_close && !tx_req && !una_next) begin
					send_pl = 1'b1;
					pl_flag = transport_pkg::FLAG_CLOSE;
					role_next = 1'b0;
					state_next = transport_pkg::ST_CLOSING;
				end else if (tx_req && !una_next) begin
					send_pl = 1'b1;
					pl_has = 1'b1;
					taken_next = 1'b1;
				end else if (want_close_next && !una_next) begin
					send_pl = 1'b1;
					pl_flag = transport_pkg::FLAG_CLOSE;
					role_next = 1'b1;
					want_close_next = 1'b0;
					state_next = transport_pkg::ST_CLOSING;
				end else if (ack_due_next) begin
					send_ack = 1'b1;
				end
			end
			transport_pkg::ST_CLOSING: begin
				if (role_reg && in_order && is_close && ack_hit) begin
					send_ack = 1'b1;
					state_next = transport_pkg::ST_CLOSED;
				end else if (role_reg && in_order && rx_hdr.has_data) begin
					send_pl = !una_next && !tx_req;
					pl_flag = transport_pkg::FLAG_CLOSE;
					want_close_next = !send_pl;
					if (!send_pl)
						state_next = transport_pkg::ST_OPEN;
				end else if (!role_reg && ack_hit) begin
					state_next = transport_pkg::ST_CLOSED;
				end else if (ack_due_next) begin
					send_ack = 1'b1;
				end
			end
			default: state_next = transport_pkg::ST_CLOSED;
		endcase
		if (send_pl) begin
			tx_hdr_next = transport_pkg::make_hdr(snd_seq_reg, exp_next,
				pl_ok, pl_flag, pl_has, tx_data);
			una_next = 1'b1;
			una_hdr_next = tx_hdr_next;
			snd_seq_next = snd_seq_reg + SEQ_ONE;
			tmr_next = '0;
			ack_due_next = 1'b0;
			tx_valid_next = 1'b1;
		end else if (send_ack) begin
			tx_hdr_next = transport_pkg::make_hdr(snd_seq_reg, exp_next,
				1'b1, transport_pkg::FLAG_NONE, 1'b0, tx_data);
			ack_due_next = 1'b0;
			tx_valid_next = 1'b1;
		end else if (timed_out) begin
			tx_hdr_next = una_hdr_reg;
			tx_valid_next = 1'b1;
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	// connection control state
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= transport_pkg::ST_CLOSED;
			snd_seq_reg <= `TC_SEQ_RESET;
			exp_reg <= `TC_SEQ_RESET;
			una_reg <= 1'b0;
			tmr_reg <= '0;
			role_reg <= 1'b0;
			want_close_reg <= 1'b0;
			ack_due_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			snd_seq_reg <= snd_seq_next;
			exp_reg <= exp_next;
			una_reg <= una_next;
			tmr_reg <= tmr_next;
			role_reg <= role_next;
			want_close_reg <= want_close_next;
			ack_due_reg <= ack_due_next;
		end
	end
	// link and user side outputs
	always_ff @(posedge mclk) begin
		if (rst) begin
			tx_valid_reg <= 1'b0;
			tx_hdr_reg <= '0;
			una_hdr_reg <= '0;
			rx_valid_reg <= 1'b0;
			rx_data_reg <= `TC_DATA_RESET;
			taken_reg <= 1'b0;
			reject_reg <= 1'b0;
		end else begin
			tx_valid_reg <= tx_valid_next;
			tx_hdr_reg <= tx_hdr_next;
			una_hdr_reg <= una_hdr_next;
			rx_valid_reg <= rx_valid_next;
			rx_data_reg <= rx_data_next;
			taken_reg <= taken_next;
			reject_reg <= reject_next;
		end
	end
	// outputs straight from the flops
	assign link.a2b_valid = tx_valid_reg;
	assign link.a2b_hdr = tx_hdr_reg;
	assign tx_taken = taken_reg;
	assign rx_valid = rx_valid_reg;
	assign rx_data = rx_data_reg;
	assign rx_reject = reject_reg;
	assign conn_state = state_reg;

endmodule : transport_end_dev

/* logic/transport_defines.svh */
/*
 * constants of the connection handshake: field widths, header codes,
 * reset values and the retransmission time.
 * assumes it is included by its bare name, before any package use.
 */
`ifndef TRANSPORT_DEFINES_SVH
`define TRANSPORT_DEFINES_SVH

// ************************************************************
// header field layout
// ************************************************************
`define TC_SEQ_W 10
`define TC_DATA_W 8
`define TC_REP_W 2
`define TC_REP_ZERO 2'h0

// connection control codes
`define TC_FLAG_NONE 2'h0
`define TC_FLAG_OPEN 2'h1
`define TC_FLAG_CLOSE 2'h2

// ************************************************************
// reset values
// ************************************************************
`define TC_SEQ_RESET 10'h000
`define TC_DATA_RESET 8'h00

// ************************************************************
// timing
// ************************************************************
`define TC_CLK_PERIOD_NS 10
`define TC_RETX_TIME_NS 2000
`define TC_RETX_CYCLES (`TC_RETX_TIME_NS / `TC_CLK_PERIOD_NS)
`define TC_TMR_W 9

`endif

/* logic/transport_pkg.sv */
/*
 * types shared by both ends: control codes, connection states and
 * the transport packet header.
 * assumes transport_defines.svh is on the include path.
 */
`include "transport_defines.svh"

package transport_pkg;

	// ************************************************************
	// codes and states
	// ************************************************************
	typedef enum logic [1:0] {
		FLAG_NONE = `TC_FLAG_NONE,
		FLAG_OPEN = `TC_FLAG_OPEN,
		FLAG_CLOSE = `TC_FLAG_CLOSE
	} flag_t;

	// gray order closed, opening, open, closing
	typedef enum logic [1:0] {
		ST_CLOSED = 2'h0,
		ST_OPENING = 2'h1,
		ST_OPEN = 2'h3,
		ST_CLOSING = 2'h2
	} conn_state_t;

	typedef logic [`TC_SEQ_W-1:0] seq_t;
	typedef logic [`TC_DATA_W-1:0] data_t;

	// ************************************************************
	// transport packet header
	// ************************************************************
	typedef struct packed {
		seq_t seq;
		seq_t ack;
		logic ack_ok;
		logic [`TC_REP_W-1:0] repeat_count_field;
		flag_t flag;
		logic has_data;
		data_t data;
	} hdr_t;

	// builds a header with the repeat field at zero
	function automatic hdr_t make_hdr(seq_t s, seq_t a, logic ok,
		flag_t f, logic h, data_t d);
		hdr_t r;
		r.seq = s;
		r.ack = a;
		r.ack_ok = ok;
		r.repeat_count_field = `TC_REP_ZERO;
		r.flag = f;
		r.has_data = h;
		r.data = h ? d : `TC_DATA_RESET;
		return r;
	endfunction : make_hdr

endpackage : transport_pkg

/* logic/transport_link_if.sv */
/*
 * the link between the two peer ends: one header channel each way.
 * assumes both ends share mclk; a packet is taken on any rising edge where
 * its valid is high, and the receiver never stalls.
 */
`timescale 1ns/100ps

interface transport_link_if;
	logic a2b_valid;
	transport_pkg::hdr_t a2b_hdr;
	logic b2a_valid;
	transport_pkg::hdr_t b2a_hdr;

	modport dev_end (output a2b_valid, output a2b_hdr,
		input b2a_valid, input b2a_hdr);
	modport peer_end (input a2b_valid, input a2b_hdr,
		output b2a_valid, output b2a_hdr);
endinterface : transport_link_if

/* logic/transport_end_peer.sv */
/*
 * peer end of the control transport link: the same symmetric entity,
 * facing the device end across the link interface.
 * assumes the device end keeps the same protocol, one clock, sync reset.
 */
`timescale 1ns/100ps
`include "transport_defines.svh"

module transport_end_peer (
	input wire logic mclk,
	input wire logic rst,
	transport_link_if.peer_end link,
	input wire logic open_cmd,
	input wire logic close_cmd,
	input wire logic tx_req,
	input wire transport_pkg::data_t tx_data,
	output logic tx_taken,
	output logic rx_valid,
	output transport_pkg::data_t rx_data,
	output logic rx_reject,
	output transport_pkg::conn_state_t conn_state
);

	// ************************************************************
	// constants and state
	// ************************************************************
	localparam transport_pkg::seq_t SEQ_ONE = `TC_SEQ_W'(1);
	localparam logic [`TC_TMR_W-1:0] TMR_LIMIT =
		`TC_TMR_W'(`TC_RETX_CYCLES - 1);
	localparam logic [`TC_TMR_W-1:0] TMR_ONE = `TC_TMR_W'(1);

	transport_pkg::conn_state_t st_reg, st_next;
	transport_pkg::seq_t snd_reg, snd_next, exp_reg, exp_next;
	transport_pkg::hdr_t una_hdr_reg, una_hdr_next, out_reg, out_next;
	transport_pkg::data_t got_reg, got_next;
	transport_pkg::flag_t pf;
	logic [`TC_TMR_W-1:0] tmr_reg, tmr_next;
	logic una_reg, una_next, init_reg, init_next, wc_reg, wc_next;
	logic due_reg, due_next, ov_reg, ov_next, gv_reg, gv_next;
	logic tk_reg, tk_next, rj_reg, rj_next;
	logic sp, sa, pok, ph;

	// ************************************************************
	// receive decode
	// ************************************************************
	transport_pkg::hdr_t h;
	logic got, pay, ord, hit, tmo, cls, take;
	assign got = link.a2b_valid;
	assign h = link.a2b_hdr;
	assign cls = h.flag == transport_pkg::FLAG_CLOSE;
	assign pay = h.has_data || cls;
	assign ord = got && h.seq == exp_reg;
	assign hit = got && h.ack_ok && una_reg && h.ack == snd_reg;
	assign tmo = una_reg && tmr_reg == TMR_LIMIT;
	assign take = ord && pay && (st_reg == transport_pkg::ST_OPEN ||
		st_reg == transport_pkg::ST_CLOSING);

	// ************************************************************
	// connection sequencing
	// ************************************************************
	always_comb begin
		st_next = st_reg;
		snd_next = snd_reg;
		exp_next = take ? h.seq + SEQ_ONE : exp_reg;
		una_next = una_reg && !hit;
		una_hdr_next = una_hdr_reg;
		tmr_next = (una_reg && !tmo) ? tmr_reg + TMR_ONE : '0;
		init_next = init_reg;
		wc_next = wc_reg || (close_cmd && st_reg == transport_pkg::ST_OPEN);
		due_next = due_reg || (got && pay &&
			st_reg[0] == st_reg[1] && st_reg != transport_pkg::ST_CLOSED);
		due_next = due_next || (got && pay && st_reg == transport_pkg::ST_CLOSING);
		gv_next = take && h.has_data;
		got_next = gv_next ? h.data : got_reg;
		ov_next = 1'b0;
		out_next = out_reg;
		tk_next = 1'b0;
		rj_next = 1'b0;
		sp = 1'b0;
		sa = 1'b0;
		pok = 1'b1;
		ph = 1'b0;
		pf = transport_pkg::FLAG_NONE;
		case (st_reg)
			transport_pkg::ST_CLOSED: begin
				una_next = 1'b0;
				due_next = 1'b0;
				wc_next = 1'b0;
				if (got && h.flag == transport_pkg::FLAG_OPEN && !h.ack_ok) begin
					exp_next = h.seq + SEQ_ONE;
					sp = 1'b1;
					pf = transport_pkg::FLAG_OPEN;
					init_next = 1'b0;
					st_next = transport_pkg::ST_OPENING;
				end else if (got) begin
					rj_next = 1'b1;
				end else if (open_cmd) begin
					sp = 1'b1;
					pok = 1'b0;
					pf = transport_pkg::FLAG_OPEN;
					init_next = 1'b1;
					st_next = transport_pkg::ST_OPENING;
				end
			end
			transport_pkg::ST_OPENING: begin
				if (hit && (!init_reg || h.flag == transport_pkg::FLAG_OPEN)) begin
					st_next = transport_pkg::ST_OPEN;
					sa = init_reg;
					if (init_reg)
						exp_next = h.seq + SEQ_ONE;
				end
			end
			transport_pkg::ST_OPEN: begin
				if (ord && cls && !tx_req && !una_next) begin
					sp = 1'b1;
					pf = transport_pkg::FLAG_CLOSE;
					init_next = 1'b0;
					st_next = transport_pkg::ST_CLOSING;
				end else if (tx_req && !una_next) begin
					sp = 1'b1;
					ph = 1'b1;
					tk_next = 1'b1;
				end else if (wc_next && !una_next) begin
					sp = 1'b1;
					pf = transport_pkg::FLAG_CLOSE;
					init_next = 1'b1;
					wc_next = 1'b0;
					st_next = transport_pkg::ST_CLOSING;
				end else begin
					sa = due_next;
				end
			end
			transport_pkg::ST_CLOSING: begin
				if (init_reg && ord && cls && hit) begin
					sa = 1'b1;
					st_next = transport_pkg::ST_CLOSED;
				end else if (init_reg && ord && h.has_data) begin
					sp = !una_next && !tx_req;
					pf = transport_pkg::FLAG_CLOSE;
					wc_next = !sp;
					if (!sp)
						st_next = transport_pkg::ST_OPEN;
				end else if (!init_reg && hit) begin
					st_next = transport_pkg::ST_CLOSED;
				end else begin
					sa = due_next;
				end
			end
			default: begin
				st_next = transport_pkg::ST_CLOSED;
			end
		endcase
		if (sp) begin
			out_next = transport_pkg::make_hdr(snd_reg, exp_next, pok, pf,
				ph, tx_data);
			una_next = 1'b1;
			una_hdr_next = out_next;
			snd_next = snd_reg + SEQ_ONE;
			tmr_next = '0;
			due_next = 1'b0;
			ov_next = 1'b1;
		end else if (sa) begin
			out_next = transport_pkg::make_hdr(snd_reg, exp_next, 1'b1,
				transport_pkg::FLAG_NONE, 1'b0, tx_data);
			due_next = 1'b0;
			ov_next = 1'b1;
		end else if (tmo) begin
			out_next = una_hdr_reg;
			ov_next = 1'b1;
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_reg <= transport_pkg::ST_CLOSED;
			snd_reg <= `TC_SEQ_RESET;
			exp_reg <= `TC_SEQ_RESET;
			una_reg <= 1'b0;
			tmr_reg <= '0;
			init_reg <= 1'b0;
			wc_reg <= 1'b0;
			due_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			snd_reg <= snd_next;
			exp_reg <= exp_next;
			una_reg <= una_next;
			tmr_reg <= tmr_next;
			init_reg <= init_next;
			wc_reg <= wc_next;
			due_reg <= due_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ov_reg <= 1'b0;
			out_reg <= '0;
			una_hdr_reg <= '0;
			gv_reg <= 1'b0;
			got_reg <= `TC_DATA_RESET;
			tk_reg <= 1'b0;
			rj_reg <= 1'b0;
		end else begin
			ov_reg <= ov_next;
			out_reg <= out_next;
			una_hdr_reg <= una_hdr_next;
			gv_reg <= gv_next;
			got_reg <= got_next;
			tk_reg <= tk_next;
			rj_reg <= rj_next;
		end
	end

	// outputs straight from the flops
	assign link.b2a_valid = ov_reg;
	assign link.b2a_hdr = out_reg;
	assign tx_taken = tk_reg;
	assign rx_valid = gv_reg;
	assign rx_data = got_reg;
	assign rx_reject = rj_reg;
	assign conn_state = st_reg;

endmodule : transport_end_peer

/* tb/transport_link_monitor.sv */
/*
 * checker of the link between the device end and the peer end.
 * assumes it sits beside the interface; one clock, sync reset.
 */
`timescale 1ns/100ps

module transport_link_monitor (
	input wire logic mclk,
	input wire logic rst,
	input wire logic a2b_valid,
	input wire transport_pkg::hdr_t a2b_hdr,
	input wire logic b2a_valid,
	input wire transport_pkg::hdr_t b2a_hdr
);
	// ************************************************************
	// packet kinds
	// ************************************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	// decode open, close and payload packets of each direction
	wire a_open;
	wire b_open;
	wire a_close;
	wire b_close;
	wire a_pay;
	wire b_pay;
	assign a_open = a2b_valid && a2b_hdr.flag == transport_pkg::FLAG_OPEN;
	assign b_open = b2a_valid && b2a_hdr.flag == transport_pkg::FLAG_OPEN;
	assign a_close = a2b_valid && a2b_hdr.flag == transport_pkg::FLAG_CLOSE;
	assign b_close = b2a_valid && b2a_hdr.flag == transport_pkg::FLAG_CLOSE;
	assign a_pay = a_open || a_close || (a2b_valid && a2b_hdr.has_data);
	assign b_pay = b_open || b_close || (b2a_valid && b2a_hdr.has_data);

	// ************************************************************
	// properties
	// ************************************************************
	property p_open_req;
		(a_open && !a2b_hdr.ack_ok |-> !a2b_hdr.has_data) and
		(b_open && !b2a_hdr.ack_ok |-> !b2a_hdr.has_data);
	endproperty
	a_open_req: assert property (p_open_req)
		else $error("open request carries data");

	property p_open_accept;
		a_open && !a2b_hdr.ack_ok |=>
		b_open && b2a_hdr.ack_ok && !b2a_hdr.has_data;
	endproperty
	a_open_accept: assert property (p_open_accept)
		else $error("open request not accepted");

	property p_open_confirm;
		b_open && b2a_hdr.ack_ok |=> a2b_valid && !a2b_hdr.has_data &&
		a2b_hdr.flag == transport_pkg::FLAG_NONE;
	endproperty
	a_open_confirm: assert property (p_open_confirm)
		else $error("open accept not confirmed");

	property p_ack_of_dev;
		a_pay |=> b2a_valid && b2a_hdr.ack == $past(a2b_hdr.seq) + 10'h001;
	endproperty
	a_ack_of_dev: assert property (p_ack_of_dev)
		else $error("device packet not acknowledged");

	property p_ack_of_peer;
		b_pay |=> a2b_valid && a2b_hdr.ack == $past(b2a_hdr.seq) + 10'h001;
	endproperty
	a_ack_of_peer: assert property (p_ack_of_peer)
		else $error("peer packet not acknowledged");

	property p_close_seq;
		a_close && !$past(b_close) |=> b2a_valid ##1
		a2b_valid && a2b_hdr.seq == $past(a2b_hdr.seq, 2) + 10'h001;
	endproperty
	a_close_seq: assert property (p_close_seq)
		else $error("close request did not consume a number");

	property p_close_coded;
		(a_close |-> a2b_hdr.ack_ok && !a2b_hdr.has_data) and
		(b_close |-> b2a_hdr.ack_ok && !b2a_hdr.has_data);
	endproperty
	a_close_coded: assert property (p_close_coded)
		else $error("close packet coded wrongly");

	property p_close_retry;
		$past(a_close) && b2a_valid && b2a_hdr.has_data && !b_close |=>
		a_close && a2b_hdr.ack == $past(b2a_hdr.seq) + 10'h001;
	endproperty
	a_close_retry: assert property (p_close_retry)
		else $error("declined close not retried");

endmodule : transport_link_monitor

/* tb/testbench.sv */
/*
 * testbench of the two ends, plus a lone device end on a second link
 * driven by the bench to reach refusal and retransmission.
 * assumes the design files and the monitor are compiled before it.
 */
`timescale 1ns/100ps

module testbench;
	// ************************************************************
	// signals and instances
	// ************************************************************
	logic mclk;
	logic rst;
	logic d_open, d_close, d_req, p_open, p_close, p_req, q_open;
	transport_pkg::data_t d_data, p_data, d_rx, p_rx;
	logic d_taken, p_taken, d_rv, p_rv, q_rej;
	transport_pkg::conn_state_t d_st, p_st, q_st;
	logic [5:0] flags;
	int bad_count;
	int checked;
	transport_link_if link ();
	transport_link_if link2 ();

	// events waited for by index
	assign flags = {link2.a2b_valid, q_rej, p_rv, d_rv, p_taken, d_taken};

	transport_end_dev i_transport_end_dev (.mclk(mclk), .rst(rst),
		.link(link), .open_cmd(d_open), .close_cmd(d_close),
		.tx_req(d_req), .tx_data(d_data), .tx_taken(d_taken),
		.rx_valid(d_rv), .rx_data(d_rx), .rx_reject(), .conn_state(d_st));
	transport_end_peer i_transport_end_peer (.mclk(mclk), .rst(rst),
		.link(link), .open_cmd(p_open), .close_cmd(p_close),
		.tx_req(p_req), .tx_data(p_data), .tx_taken(p_taken),
		.rx_valid(p_rv), .rx_data(p_rx), .rx_reject(), .conn_state(p_st));
	transport_end_dev i_transport_end_dev_2 (.mclk(mclk), .rst(rst),
		.link(link2), .open_cmd(q_open), .close_cmd(1'b0),
		.tx_req(1'b0), .tx_data(8'h00), .tx_taken(), .rx_valid(),
		.rx_data(), .rx_reject(q_rej), .conn_state(q_st));
	transport_link_monitor i_transport_link_monitor (.mclk(mclk),
		.rst(rst), .a2b_valid(link.a2b_valid), .a2b_hdr(link.a2b_hdr),
		.b2a_valid(link.b2a_valid), .b2a_hdr(link.b2a_hdr));

	// ************************************************************
	// helpers
	// ************************************************************
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic cmp_val(input logic [9:0] got, input logic [9:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask : cmp_val

	task automatic cmp_hdr(input transport_pkg::hdr_t got,
		input transport_pkg::hdr_t exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask : cmp_hdr

	// waits at falling edges for a flag, bounded, then checks it
	task automatic wait_flag(input int i, input int lim, output int n);
		n = 0;
		while (flags[i] !== 1'b1 && n < lim) begin
			@(negedge mclk);
			n++;
		end
		cmp_val(10'(flags[i]), 10'h001);
	endtask : wait_flag

	task automatic wait_both(input transport_pkg::conn_state_t e);
		int n;
		n = 0;
		while ((d_st !== e || p_st !== e) && n < 40) begin
			@(negedge mclk);
			n++;
		end
		cmp_val(10'(d_st), 10'(e));
		cmp_val(10'(p_st), 10'(e));
	endtask : wait_both

	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_open(input logic from_dev);
		@(negedge mclk);
		d_open = from_dev;
		p_open = !from_dev;
		@(negedge mclk);
		d_open = 1'b0;
		p_open = 1'b0;
		wait_both(transport_pkg::ST_OPEN);
		$display("test open done");
	endtask : t_open

	task automatic t_data;
		int n;
		d_data = 8'hA5;
		d_req = 1'b1;
		wait_flag(0, 10, n);
		d_req = 1'b0;
		wait_flag(3, 10, n);
		cmp_val(10'(p_rx), 10'h0A5);
		p_data = 8'h3C;
		p_req = 1'b1;
		wait_flag(1, 10, n);
		p_req = 1'b0;
		wait_flag(2, 10, n);
		cmp_val(10'(d_rx), 10'h03C);
		$display("test data done");
	endtask : t_data

	task automatic t_peer_close;
		@(negedge mclk);
		p_close = 1'b1;
		@(negedge mclk);
		p_close = 1'b0;
		wait_both(transport_pkg::ST_CLOSED);
		$display("test peer close done");
	endtask : t_peer_close

	// peer raises data just as the close request reaches it
	task automatic t_decline;
		int n;
		@(negedge mclk);
		d_close = 1'b1;
		@(negedge mclk);
		d_close = 1'b0;
		p_data = 8'h5A;
		p_req = 1'b1;
		wait_flag(1, 10, n);
		p_req = 1'b0;
		wait_flag(2, 10, n);
		cmp_val(10'(d_rx), 10'h05A);
		wait_both(transport_pkg::ST_CLOSED);
		$display("test declined close done");
	endtask : t_decline

	task automatic t_reject;
		int n;
		@(negedge mclk);
		link2.b2a_hdr = '{seq: 10'h005, ack: 10'h000, ack_ok: 1'b1,
			repeat_count_field: 2'h0, flag: transport_pkg::FLAG_NONE, has_data: 1'b1,
			data: 8'h77};
		link2.b2a_valid = 1'b1;
		@(negedge mclk);
		link2.b2a_valid = 1'b0;
		wait_flag(4, 5, n);
		cmp_val(10'(q_st), 10'(transport_pkg::ST_CLOSED));
		$display("test reject done");
	endtask : t_reject

	// open request left unanswered must come again unchanged
	task automatic t_retx;
		transport_pkg::hdr_t h;
		int n;
		@(negedge mclk);
		q_open = 1'b1;
		wait_flag(5, 5, n);
		q_open = 1'b0;
		h = link2.a2b_hdr;
		cmp_val(10'(h.flag), 10'(transport_pkg::FLAG_OPEN));
		cmp_val(10'(h.ack_ok), 10'h000);
		@(negedge mclk);
		wait_flag(5, 260, n);
		cmp_hdr(link2.a2b_hdr, h);
		cmp_val(10'(n > 190 && n < 210), 10'h001);
		$display("test retransmit done");
	endtask : t_retx

	// ************************************************************
	// main sequence and watchdog
	// ************************************************************
	initial begin
		bad_count = 0;
		checked = 0;
		rst = 1'b1;
		{d_open, d_close, d_req, p_open, p_close, p_req, q_open} = 7'h00;
		d_data = 8'h00;
		p_data = 8'h00;
		link2.b2a_valid = 1'b0;
		link2.b2a_hdr = '0;
		repeat (12) @(negedge mclk);
		rst = 1'b0;
		t_open(1'b1);
		t_data;
		t_peer_close;
		t_open(1'b0);
		t_decline;
		t_reject;
		t_retx;
		tally_and_finish;
	end

	initial begin
		#20000;
		bad_count++;
		tally_and_finish;
	end

endmodule : testbench
